// *** src/room_air_regs.svh ***
// Contract
// - Registers and readings reachable over Modbus port
// - Output demand is largest channel demand
// - Disabled channels excluded from maximum selection
// - TVOC range selectable from zero to 60000
// - Fifteen minute warm-up, green blinks, TVOC zero
// - Green steady inside alert window
// - Yellow while value outside alert window
// - Red steady when outside measurement range
// - Red blinks on sensor element fault
// - Bootloader alternates green/yellow, red on download
// - Indication follows TVOC unless selector says otherwise
// - Brightness zero to full in tenths
// - Brightness zero turns every indicator off
// - Lux reading published as input register
// - Active and standby light levels held
// - Light class standby, low intensity or active
// - Bus termination resistor switched by register
`ifndef ROOM_AIR_REGS_SVH
`define ROOM_AIR_REGS_SVH

`define HR_BUS_TERM 16'h0009
`define HR_LIGHT_ACTIVE 16'h0023
`define HR_LIGHT_STANDBY 16'h0024
`define HR_IND_SELECT 16'h004F
`define HR_BRIGHTNESS 16'h0050
`define HR_CHAN_ENABLE 16'h0060
`define HR_TVOC_RANGE 16'h0061
`define IR_LIGHT_LUX 16'h0029
`define IR_LIGHT_CLASS 16'h002A
`define IR_TEMP 16'h0060
`define IR_RELATIVE_HUMIDITY 16'h0061
`define IR_TVOC 16'h0062
`define IR_DEMAND 16'h0063
`define IR_STATUS 16'h0064

`define FC_READ_HOLD 8'h03
`define FC_READ_INPUT 8'h04
`define FC_WRITE_SINGLE 8'h06
`define EX_BAD_FUNC 8'h01
`define EX_BAD_ADDR 8'h02
`define EX_BAD_VALUE 8'h03

`define SEL_TVOC 2'h0
`define SEL_TEMP 2'h1
`define SEL_RELATIVE_HUMIDITY 2'h2
`define CLASS_STANDBY 2'h0
`define CLASS_LOW 2'h1
`define CLASS_ACTIVE 2'h2

`define RST_BUS_TERM 1'h0
`define RST_LIGHT_ACTIVE 16'h01F4
`define RST_LIGHT_STANDBY 16'h0032
`define RST_BRIGHTNESS 7'h64
`define RST_CHAN_ENABLE 3'h7
`define RST_TVOC_RANGE 16'hEA60
`define TVOC_SPAN_MAX 16'hEA60
`define BRIGHT_MAX 16'h0064
`define BRIGHT_STEP 7'h0A
`define PWM_PHASES 4'hA

`define CLK_HZ 25000000
`define WARMUP_MIN 15
`define BLINK_MS 500
`define PWM_SLOT_US 100

`endif

// *** src/room_air_pkg.sv ***
package room_air_pkg;

  typedef enum logic [1:0] {
    MODE_WARMUP = 2'b00,
    MODE_RUN = 2'b01,
    MODE_BOOT = 2'b11
  } mode_t;

  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mb_req_t;

  typedef struct packed {
    logic valid;
    logic exception;
    logic [7:0] code;
    logic [15:0] data;
  } mb_rsp_t;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } led_t;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] relative_humidity;
    logic [15:0] tvoc;
  } triple_t;

  typedef struct packed {
    logic [15:0] range_min;
    logic [15:0] range_max;
    logic [15:0] alert_min;
    logic [15:0] alert_max;
  } limits_t;

  typedef struct packed {
    mode_t mode;
    logic [35:0] warm_cnt;
    logic [23:0] blink_cnt;
    logic blink;
    logic [11:0] slot_cnt;
    logic [3:0] pwm_phase;
    logic bus_term;
    logic [15:0] light_active;
    logic [15:0] light_standby;
    logic [15:0] lux;
    logic [1:0] light_class;
    logic [1:0] ind_select;
    logic [6:0] brightness;
    logic [2:0] chan_en;
    logic [15:0] tvoc_range;
    led_t led;
    logic [15:0] demand;
    mb_rsp_t rsp;
  } state_t;

endpackage

// *** src/room_air_status.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "room_air_regs.svh"

module room_air_status #(
  parameter longint unsigned WARMUP_CYCLES = 64'(`WARMUP_MIN) * 64'd60 * 64'(`CLK_HZ),
  parameter int unsigned BLINK_CYCLES = `BLINK_MS * (`CLK_HZ / 1000),
  parameter int unsigned PWM_SLOT_CYCLES = `PWM_SLOT_US * (`CLK_HZ / 1000000)
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire room_air_pkg::mb_req_t req,
  output room_air_pkg::mb_rsp_t rsp,
  input wire room_air_pkg::triple_t meas,
  input wire room_air_pkg::triple_t chan_demand,
  input wire room_air_pkg::limits_t temp_lim,
  input wire room_air_pkg::limits_t relative_humidity_lim,
  input wire room_air_pkg::limits_t tvoc_lim,
  input wire logic lux_valid,
  input wire logic [15:0] lux_value,
  input wire logic sensor_fault,
  input wire logic bootloader_mode,
  input wire logic download_active,
  output room_air_pkg::led_t led,
  output logic [15:0] output_demand,
  output logic bus_termination_resistor_en
);

  if (WARMUP_CYCLES < 1 || WARMUP_CYCLES > 64'h0000_000F_FFFF_FFFF) begin : g_bad_warmup
    $error("WARMUP_CYCLES does not fit the warm-up counter");
  end
  if (BLINK_CYCLES < 1 || BLINK_CYCLES > 32'h00FF_FFFF) begin : g_bad_blink
    $error("BLINK_CYCLES does not fit the blink counter");
  end
  if (PWM_SLOT_CYCLES < 1 || PWM_SLOT_CYCLES > 32'h0000_0FFF) begin : g_bad_slot
    $error("PWM_SLOT_CYCLES does not fit the slot counter");
  end

  localparam logic [35:0] WARM_LAST = 36'(WARMUP_CYCLES - 64'd1);
  localparam logic [23:0] BLINK_LAST = 24'(BLINK_CYCLES - 1);
  localparam logic [11:0] SLOT_LAST = 12'(PWM_SLOT_CYCLES - 1);

  room_air_pkg::state_t s_reg;
  room_air_pkg::state_t s_next;

  logic warm_done;
  logic [15:0] tvoc_report;
  logic [15:0] tvoc_dem;
  logic [15:0] ind_value;
  room_air_pkg::limits_t ind_lim;
  logic out_of_range;
  logic in_window;
  logic [3:0] level;
  logic pwm_on;
  logic is_read_hold;
  logic is_read_input;
  logic is_write;

  // Warm-up counter parks at its last value, so the flag stays set
  assign warm_done = (s_reg.warm_cnt == WARM_LAST);

  // Reading not trustworthy during warm-up: report and use zero
  assign tvoc_report = warm_done ? meas.tvoc : 16'h0000;
  assign tvoc_dem = warm_done ? chan_demand.tvoc : 16'h0000;

  // Indicated quantity and its limits
  always_comb begin
    ind_value = meas.tvoc;
    ind_lim = tvoc_lim;
    ind_lim.range_min = 16'h0000;
    ind_lim.range_max = s_reg.tvoc_range;
    if (s_reg.ind_select == `SEL_TEMP) begin
      ind_value = meas.temp;
      ind_lim = temp_lim;
    end else if (s_reg.ind_select == `SEL_RELATIVE_HUMIDITY) begin
      ind_value = meas.relative_humidity;
      ind_lim = relative_humidity_lim;
    end
  end

  assign out_of_range = (ind_value < ind_lim.range_min) || (ind_value > ind_lim.range_max);
  assign in_window = (ind_value >= ind_lim.alert_min) && (ind_value <= ind_lim.alert_max);

  // Ten PWM phases: level n keeps the LEDs lit for n tenths
  assign level = 4'(s_reg.brightness / `BRIGHT_STEP);
  assign pwm_on = (s_reg.pwm_phase < level);

  assign is_read_hold = req.valid && (req.func == `FC_READ_HOLD);
  assign is_read_input = req.valid && (req.func == `FC_READ_INPUT);
  assign is_write = req.valid && (req.func == `FC_WRITE_SINGLE);

  always_comb begin
    s_next = s_reg;

    // Blink and PWM time bases
    if (s_reg.blink_cnt == BLINK_LAST) begin
      s_next.blink_cnt = 24'h00_0000;
      s_next.blink = ~s_reg.blink;
    end else begin
      s_next.blink_cnt = s_reg.blink_cnt + 24'h00_0001;
    end
    if (s_reg.slot_cnt == SLOT_LAST) begin
      s_next.slot_cnt = 12'h000;
      if (s_reg.pwm_phase == `PWM_PHASES - 4'h1) begin
        s_next.pwm_phase = 4'h0;
      end else begin
        s_next.pwm_phase = s_reg.pwm_phase + 4'h1;
      end
    end else begin
      s_next.slot_cnt = s_reg.slot_cnt + 12'h001;
    end

    // Warm-up time runs from power-up whatever the mode
    if (!warm_done) begin
      s_next.warm_cnt = s_reg.warm_cnt + 36'h0_0000_0001;
    end

    case (s_reg.mode)
      room_air_pkg::MODE_WARMUP: begin
        if (bootloader_mode) begin
          s_next.mode = room_air_pkg::MODE_BOOT;
        end else if (warm_done) begin
          s_next.mode = room_air_pkg::MODE_RUN;
        end
      end
      room_air_pkg::MODE_RUN: begin
        if (bootloader_mode) begin
          s_next.mode = room_air_pkg::MODE_BOOT;
        end
      end
      room_air_pkg::MODE_BOOT: begin
        if (!bootloader_mode) begin
          s_next.mode = warm_done ? room_air_pkg::MODE_RUN : room_air_pkg::MODE_WARMUP;
        end
      end
      default: begin
        s_next.mode = room_air_pkg::MODE_WARMUP;
      end
    endcase

    // Light classification, refreshed only on a new sample
    if (lux_valid) begin
      s_next.lux = lux_value;
      if (lux_value < s_reg.light_standby) begin
        s_next.light_class = `CLASS_STANDBY;
      end else if (lux_value > s_reg.light_active) begin
        s_next.light_class = `CLASS_ACTIVE;
      end else begin
        s_next.light_class = `CLASS_LOW;
      end
    end

    // Largest demand of the enabled channels
    s_next.demand = 16'h0000;
    if (s_reg.chan_en[0]) begin
      s_next.demand = chan_demand.temp;
    end
    if (s_reg.chan_en[1] && (chan_demand.relative_humidity > s_next.demand)) begin
      s_next.demand = chan_demand.relative_humidity;
    end
    if (s_reg.chan_en[2] && (tvoc_dem > s_next.demand)) begin
      s_next.demand = tvoc_dem;
    end

    // Indicator pattern
    s_next.led = '0;
    case (s_reg.mode)
      room_air_pkg::MODE_BOOT: begin
        s_next.led.green = s_reg.blink;
        s_next.led.yellow = ~s_reg.blink;
        s_next.led.red = download_active && s_reg.blink;
      end
      room_air_pkg::MODE_RUN: begin
        if (sensor_fault) begin
          s_next.led.red = s_reg.blink;
        end else if (out_of_range) begin
          s_next.led.red = 1'b1;
        end else if (!in_window) begin
          s_next.led.yellow = 1'b1;
        end else begin
          s_next.led.green = 1'b1;
        end
      end
      default: begin
        s_next.led.green = s_reg.blink;
      end
    endcase
    if (!pwm_on) begin
      s_next.led = '0;
    end

    // Register port: answer every request on the next edge
    s_next.rsp = '0;
    if (req.valid) begin
      s_next.rsp.valid = 1'b1;
    end
    if (is_read_hold) begin
      if (req.addr == `HR_BUS_TERM) begin
        s_next.rsp.data = {15'h0000, s_reg.bus_term};
      end else if (req.addr == `HR_LIGHT_ACTIVE) begin
        s_next.rsp.data = s_reg.light_active;
      end else if (req.addr == `HR_LIGHT_STANDBY) begin
        s_next.rsp.data = s_reg.light_standby;
      end else if (req.addr == `HR_IND_SELECT) begin
        s_next.rsp.data = {14'h0000, s_reg.ind_select};
      end else if (req.addr == `HR_BRIGHTNESS) begin
        s_next.rsp.data = {9'h000, s_reg.brightness};
      end else if (req.addr == `HR_CHAN_ENABLE) begin
        s_next.rsp.data = {13'h0000, s_reg.chan_en};
      end else if (req.addr == `HR_TVOC_RANGE) begin
        s_next.rsp.data = s_reg.tvoc_range;
      end else begin
        s_next.rsp.exception = 1'b1;
        s_next.rsp.code = `EX_BAD_ADDR;
      end
    end else if (is_read_input) begin
      if (req.addr == `IR_LIGHT_LUX) begin
        s_next.rsp.data = s_reg.lux;
      end else if (req.addr == `IR_LIGHT_CLASS) begin
        s_next.rsp.data = {14'h0000, s_reg.light_class};
      end else if (req.addr == `IR_TEMP) begin
        s_next.rsp.data = meas.temp;
      end else if (req.addr == `IR_RELATIVE_HUMIDITY) begin
        s_next.rsp.data = meas.relative_humidity;
      end else if (req.addr == `IR_TVOC) begin
        s_next.rsp.data = tvoc_report;
      end else if (req.addr == `IR_DEMAND) begin
        s_next.rsp.data = s_reg.demand;
      end else if (req.addr == `IR_STATUS) begin
        s_next.rsp.data = {12'h000, sensor_fault, warm_done, s_reg.mode};
      end else begin
        s_next.rsp.exception = 1'b1;
        s_next.rsp.code = `EX_BAD_ADDR;
      end
    end else if (is_write) begin
      if (req.addr == `HR_BUS_TERM) begin
        s_next.bus_term = req.wdata[0];
      end else if (req.addr == `HR_LIGHT_ACTIVE) begin
        s_next.light_active = req.wdata;
      end else if (req.addr == `HR_LIGHT_STANDBY) begin
        s_next.light_standby = req.wdata;
      end else if (req.addr == `HR_IND_SELECT && req.wdata <= {14'h0000, `SEL_RELATIVE_HUMIDITY}) begin
        s_next.ind_select = req.wdata[1:0];
      end else if (req.addr == `HR_BRIGHTNESS && req.wdata <= `BRIGHT_MAX) begin
        s_next.brightness = req.wdata[6:0];
      end else if (req.addr == `HR_CHAN_ENABLE && req.wdata <= 16'h0007) begin
        s_next.chan_en = req.wdata[2:0];
      end else if (req.addr == `HR_TVOC_RANGE && req.wdata <= `TVOC_SPAN_MAX) begin
        s_next.tvoc_range = req.wdata;
      end else if (req.addr == `HR_IND_SELECT || req.addr == `HR_BRIGHTNESS
                   || req.addr == `HR_CHAN_ENABLE || req.addr == `HR_TVOC_RANGE) begin
        s_next.rsp.exception = 1'b1;
        s_next.rsp.code = `EX_BAD_VALUE;
      end else begin
        s_next.rsp.exception = 1'b1;
        s_next.rsp.code = `EX_BAD_ADDR;
      end
      // Write echoes the full 16-bit write value, even where the register keeps only bit 0 of it
      if (!s_next.rsp.exception) begin
        s_next.rsp.data = req.wdata;
      end
    end else if (req.valid) begin
      s_next.rsp.exception = 1'b1;
      s_next.rsp.code = `EX_BAD_FUNC;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.mode <= room_air_pkg::MODE_WARMUP;
      s_reg.bus_term <= `RST_BUS_TERM;
      s_reg.light_active <= `RST_LIGHT_ACTIVE;
      s_reg.light_standby <= `RST_LIGHT_STANDBY;
      s_reg.ind_select <= `SEL_TVOC;
      s_reg.brightness <= `RST_BRIGHTNESS;
      s_reg.chan_en <= `RST_CHAN_ENABLE;
      s_reg.tvoc_range <= `RST_TVOC_RANGE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rsp = s_reg.rsp;
  assign led = s_reg.led;
  assign output_demand = s_reg.demand;
  assign bus_termination_resistor_en = s_reg.bus_term;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_rsp_next_cycle: assert property (req.valid |=> rsp.valid)
    else $error("request not answered on the next edge");

  a_bad_func_code: assert property (
    req.valid && req.func != `FC_READ_HOLD && req.func != `FC_READ_INPUT
    && req.func != `FC_WRITE_SINGLE |=> rsp.exception && rsp.code == `EX_BAD_FUNC)
    else $error("unknown function not refused");

  a_demand_is_max: assert property (
    s_reg.chan_en == 3'h7 && warm_done |=> output_demand >= $past(chan_demand.temp)
    && output_demand >= $past(chan_demand.relative_humidity) && output_demand >= $past(chan_demand.tvoc))
    else $error("demand below an enabled channel");

  a_tvoc_only: assert property (
    s_reg.chan_en == 3'h4 && warm_done |=> output_demand == $past(chan_demand.tvoc))
    else $error("disabled channel affects demand");

  a_tvoc_span_limit: assert property (
    is_write && req.addr == `HR_TVOC_RANGE && req.wdata > `TVOC_SPAN_MAX
    |=> rsp.exception && $stable(s_reg.tvoc_range))
    else $error("TVOC range beyond span accepted");

  a_warmup_tvoc_zero: assert property (
    !warm_done && is_read_input && req.addr == `IR_TVOC |=> rsp.data == 16'h0000)
    else $error("TVOC reported during warm-up");

  a_dark_all_off: assert property (s_reg.brightness == 7'h00 |=> led == 3'h0)
    else $error("LED lit at zero brightness");

  a_one_led_run: assert property (s_reg.mode == room_air_pkg::MODE_RUN |=> $onehot0(led))
    else $error("more than one LED in normal mode");

  a_red_out_range: assert property (
    s_reg.mode == room_air_pkg::MODE_RUN && !sensor_fault && out_of_range && pwm_on |=> led.red)
    else $error("red not lit when out of range");

  a_boot_alternate: assert property (
    s_reg.mode == room_air_pkg::MODE_BOOT && pwm_on |=> led.green != led.yellow)
    else $error("bootloader LEDs not alternating");

  a_class_standby: assert property (
    lux_valid && lux_value < s_reg.light_standby |=> s_reg.light_class == `CLASS_STANDBY)
    else $error("light class not standby");

endmodule // room_air_status

`default_nettype wire

// *** tb/modbus_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module modbus_master_model (
  input wire logic ref_clk,
  output var room_air_pkg::mb_req_t req,
  input wire room_air_pkg::mb_rsp_t rsp
);
  initial req = '0;

  // Idle fields carry the inverse of the last request so nothing stale can pass for a live one
  task automatic run(input logic [7:0] func, input logic [15:0] addr, input logic [15:0] wdata,
                     output room_air_pkg::mb_rsp_t r);
    @(posedge ref_clk);
    req <= '{valid: 1'b1, func: func, addr: addr, wdata: wdata};
    @(posedge ref_clk);
    req <= '{valid: 1'b0, func: ~func, addr: ~addr, wdata: ~wdata};
    @(posedge ref_clk);
    r = rsp;
  endtask
endmodule // modbus_master_model

`default_nettype wire

// *** tb/test_room_air_sensor_status_logic.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "room_air_regs.svh"

module test_room_air_sensor_status_logic;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  room_air_pkg::mb_req_t req;
  room_air_pkg::mb_rsp_t rsp;
  room_air_pkg::triple_t meas = {16'h0000, 16'h0000, 16'h012C};
  room_air_pkg::triple_t chan_demand = {16'h0064, 16'h012C, 16'h01F4};
  room_air_pkg::limits_t temp_lim = {16'h0000, 16'h03E8, 16'h0064, 16'h0190};
  room_air_pkg::limits_t relative_humidity_lim = {16'h0000, 16'h03E8, 16'h0064, 16'h0190};
  room_air_pkg::limits_t tvoc_lim = {16'h0000, 16'h0000, 16'h0064, 16'h0190};
  logic lux_valid = 1'b0;
  logic [15:0] lux_value = 16'h0000;
  logic sensor_fault = 1'b0;
  logic bootloader_mode = 1'b0;
  logic download_active = 1'b0;
  room_air_pkg::led_t led;
  logic [15:0] output_demand;
  logic bus_termination_resistor_en;
  int failures = 0;
  int checks = 0;
  int n_g, n_y, n_r, n_same;

  always #20 ref_clk = ~ref_clk;

  // Short counts keep the run small: warm-up 200 cycles, blink toggles every 4, PWM slot of 1
  room_air_status #(.WARMUP_CYCLES(200), .BLINK_CYCLES(4), .PWM_SLOT_CYCLES(1)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rsp(rsp), .meas(meas), .chan_demand(chan_demand),
    .temp_lim(temp_lim), .relative_humidity_lim(relative_humidity_lim), .tvoc_lim(tvoc_lim),
    .lux_valid(lux_valid),
    .lux_value(lux_value), .sensor_fault(sensor_fault), .bootloader_mode(bootloader_mode),
    .download_active(download_active), .led(led), .output_demand(output_demand),
    .bus_termination_resistor_en(bus_termination_resistor_en));

  modbus_master_model u_master (.ref_clk(ref_clk), .req(req), .rsp(rsp));

  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] func, input logic [15:0] addr, input logic [15:0] wdata,
                      input logic [7:0] code, input logic [15:0] data);
    room_air_pkg::mb_rsp_t r;
    u_master.run(func, addr, wdata, r);
    chk({6'h00, r.valid, r.exception, r.code}, {6'h00, 1'b1, code != 8'h00, code});
    if (code == 8'h00)
      chk(r.data, data);
  endtask

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    xfer(`FC_WRITE_SINGLE, addr, data, 8'h00, data);
  endtask

  task automatic rdi(input logic [15:0] addr, input logic [15:0] exp);
    xfer(`FC_READ_INPUT, addr, 16'h0000, 8'h00, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Counts lit cycles per colour, packed green/yellow/red in five bits each
  task automatic pat(input int n, input logic [15:0] exp);
    n_g = 0; n_y = 0; n_r = 0; n_same = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if (led.green === 1'b1) n_g++;
      if (led.yellow === 1'b1) n_y++;
      if (led.red === 1'b1) n_r++;
      if (led.green === led.yellow) n_same++;
    end
    chk({1'b0, 5'(n_g), 5'(n_y), 5'(n_r)}, exp);
  endtask

  task automatic test_warmup;
    rdi(`IR_STATUS, 16'h0000);
    rdi(`IR_TVOC, 16'h0000);
    pat(16, 16'h2000);
    chk(output_demand, 16'h012C);
    $display("test warmup done");
  endtask

  task automatic test_refusals;
    logic [47:0] t [8];
    t = '{{8'h10, `IR_STATUS, 16'h0000, 8'h01}, {`FC_READ_HOLD, 16'h0100, 16'h0000, 8'h02},
          {`FC_READ_INPUT, `HR_BUS_TERM, 16'h0000, 8'h02}, {`FC_WRITE_SINGLE, `IR_LIGHT_LUX, 16'h0005, 8'h02},
          {`FC_WRITE_SINGLE, `HR_IND_SELECT, 16'h0003, 8'h03}, {`FC_WRITE_SINGLE, `HR_BRIGHTNESS, 16'h0065, 8'h03},
          {`FC_WRITE_SINGLE, `HR_CHAN_ENABLE, 16'h0008, 8'h03}, {`FC_WRITE_SINGLE, `HR_TVOC_RANGE, 16'hEA61, 8'h03}};
    foreach (t[i])
      xfer(t[i][47:40], t[i][39:24], t[i][23:8], t[i][7:0], 16'h0000);
    $display("test refusals done");
  endtask

  task automatic test_reset_values;
    logic [31:0] t [7];
    t = '{{`HR_BUS_TERM, 16'h0000}, {`HR_LIGHT_ACTIVE, 16'h01F4}, {`HR_LIGHT_STANDBY, 16'h0032},
          {`HR_IND_SELECT, 16'h0000}, {`HR_BRIGHTNESS, 16'h0064}, {`HR_CHAN_ENABLE, 16'h0007},
          {`HR_TVOC_RANGE, 16'hEA60}};
    foreach (t[i])
      xfer(`FC_READ_HOLD, t[i][31:16], 16'h0000, 8'h00, t[i][15:0]);
    $display("test reset values done");
  endtask

  task automatic test_termination;
    wr(`HR_BUS_TERM, 16'h0001);
    chk({15'h0000, bus_termination_resistor_en}, 16'h0001);
    wr(`HR_BUS_TERM, 16'h0000);
    chk({15'h0000, bus_termination_resistor_en}, 16'h0000);
    $display("test termination done");
  endtask

  task automatic test_light;
    logic [15:0] lux [5];
    logic [15:0] cls [5];
    lux = '{16'h000A, 16'h0014, 16'h0032, 16'h0064, 16'h00C8};
    cls = '{16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0002};
    wr(`HR_LIGHT_ACTIVE, 16'h0064);
    wr(`HR_LIGHT_STANDBY, 16'h0014);
    foreach (lux[i]) begin
      @(posedge ref_clk);
      lux_valid <= 1'b1;
      lux_value <= lux[i];
      @(posedge ref_clk);
      lux_valid <= 1'b0;
      lux_value <= ~lux[i];
      rdi(`IR_LIGHT_LUX, lux[i]);
      rdi(`IR_LIGHT_CLASS, cls[i]);
    end
    $display("test light done");
  endtask

  task automatic wait_run;
    room_air_pkg::mb_rsp_t r;
    int k;
    for (k = 0; k < 100; k++) begin
      u_master.run(`FC_READ_INPUT, `IR_STATUS, 16'h0000, r);
      if (r.data[1:0] === 2'b01) break;
    end
    if (k == 100) begin
      failures++;
      $display("ERROR at %0t got %h expected %h", $time, r.data, 16'h0005);
      complete_run();
    end
    rdi(`IR_STATUS, 16'h0005);
    rdi(`IR_TVOC, 16'h012C);
  endtask

  task automatic test_demand;
    logic [15:0] en [3];
    logic [15:0] ex [3];
    en = '{16'h0003, 16'h0004, 16'h0001};
    ex = '{16'h012C, 16'h01F4, 16'h0064};
    chk(output_demand, 16'h01F4);
    rdi(`IR_DEMAND, 16'h01F4);
    foreach (en[i]) begin
      wr(`HR_CHAN_ENABLE, en[i]);
      settle(2);
      chk(output_demand, ex[i]);
    end
    wr(`HR_CHAN_ENABLE, 16'h0007);
    $display("test demand done");
  endtask

  task automatic test_leds;
    logic [15:0] v [3];
    logic [15:0] e [3];
    v = '{16'h00C8, 16'h01F4, 16'h05DC};
    e = '{16'h2800, 16'h0140, 16'h000A};
    wr(`HR_TVOC_RANGE, 16'h03E8);
    foreach (v[i]) begin
      @(posedge ref_clk);
      meas.tvoc <= v[i];
      settle(2);
      pat(10, e[i]);
    end
    @(posedge ref_clk);
    sensor_fault <= 1'b1;
    settle(2);
    pat(16, 16'h0008);
    rdi(`IR_STATUS, 16'h000D);
    @(posedge ref_clk);
    sensor_fault <= 1'b0;
    meas.temp <= 16'h0258;
    meas.relative_humidity <= 16'h04B0;
    wr(`HR_IND_SELECT, {14'h0000, `SEL_TEMP});
    pat(10, 16'h0140);
    wr(`HR_IND_SELECT, {14'h0000, `SEL_RELATIVE_HUMIDITY});
    pat(10, 16'h000A);
    rdi(`IR_TEMP, 16'h0258);
    rdi(`IR_RELATIVE_HUMIDITY, 16'h04B0);
    wr(`HR_IND_SELECT, {14'h0000, `SEL_TVOC});
    @(posedge ref_clk);
    meas.tvoc <= 16'h00C8;
    wr(`HR_BRIGHTNESS, 16'h0032);
    pat(20, 16'h2800);
    wr(`HR_BRIGHTNESS, 16'h0000);
    @(posedge ref_clk);
    sensor_fault <= 1'b1;
    settle(2);
    pat(20, 16'h0000);
    @(posedge ref_clk);
    sensor_fault <= 1'b0;
    wr(`HR_BRIGHTNESS, 16'h0064);
    $display("test leds done");
  endtask

  task automatic test_boot;
    @(posedge ref_clk);
    bootloader_mode <= 1'b1;
    download_active <= 1'b1;
    rdi(`IR_STATUS, 16'h0007);
    pat(16, 16'h2108);
    chk(16'(n_same), 16'h0000);
    @(posedge ref_clk);
    download_active <= 1'b0;
    settle(2);
    pat(16, 16'h2100);
    @(posedge ref_clk);
    bootloader_mode <= 1'b0;
    $display("test boot done");
  endtask

  initial begin
    settle(16);
    rst_b <= 1'b1;
    test_warmup();
    test_refusals();
    test_reset_values();
    test_termination();
    test_light();
    wait_run();
    test_demand();
    test_leds();
    test_boot();
    complete_run();
  end
endmodule // test_room_air_sensor_status_logic

`default_nettype wire
